// ===== logic/pcc_pkg.sv
// shared constants and types for the synth2 calibration and program counter
package pcc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PCC_SYNTH2_CAL_WAIT_REG  = 8'h85;
  localparam logic [7:0] PCC_SYNTH2_BANDWIDTH_REG = 8'h86;
  localparam logic [7:0] PCC_PROGRAM_CYCLE_COUNT  = 8'h88;
  localparam logic [7:0] PCC_PROGRAM_CTRL_REG     = 8'h89;
  localparam logic [7:0] PCC_PROGRAM_UNLOCK_REG   = 8'h8f;
  localparam logic [7:0] PCC_UNLOCK_CODE          = 8'hc5;

  // field positions
  localparam int PCC_OSC_WAIT_LSB   = 0;
  localparam int PCC_CL_WAIT_LSB    = 2;
  localparam int PCC_BW_MODE_BIT    = 0;
  localparam int PCC_PROG_START_BIT = 0;
  localparam int PCC_PROG_BUSY_BIT  = 2;
  localparam int PCC_COMMIT_BIT     = 3;

  // reset values
  localparam logic [1:0] PCC_CL_WAIT_RST  = 2'h0;
  localparam logic [1:0] PCC_OSC_WAIT_RST = 2'h1;
  localparam logic       PCC_BW_MODE_RST  = 1'b0;
  localparam logic [7:0] PCC_COUNT_RST    = 8'h00;
  localparam logic [7:0] PCC_COUNT_MAX    = 8'hff;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PCC_CLK_HZ  = 40_000_000;
  localparam int PCC_US_DIV  = PCC_CLK_HZ / 1_000_000;
  localparam int PCC_CL_WAIT0_US  = 30;
  localparam int PCC_CL_WAIT1_US  = 300;
  localparam int PCC_CL_WAIT2_MS  = 30;
  localparam int PCC_CL_WAIT3_MS  = 300;
  localparam int PCC_OSC_WAIT0_US = 20;
  localparam int PCC_OSC_WAIT1_US = 400;
  localparam int PCC_OSC_WAIT2_MS = 8;
  localparam int PCC_OSC_WAIT3_MS = 200;
  localparam int PCC_PROG_MS      = 230;

  // ----------------------------------------------------------------
  // register access carried from the serial port to the bank
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcc_req_t;
endpackage

// ===== logic/pcc_serial_slave.sv
// two-wire serial slave with register pointer and auto increment
`timescale 1ns/1ps
module pcc_serial_slave
  import pcc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h50  // arbitrary value
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output      logic       sda_o,
  output      logic       sda_oe,
  output      logic [7:0] rd_addr,
  input  wire logic [7:0] rd_data,
  output      pcc_req_t   req
);
  typedef enum logic [4:0] {
    SS_IDLE = 5'b00001,
    SS_DEV  = 5'b00010,
    SS_REG  = 5'b00100,
    SS_WDAT = 5'b01000,
    SS_RDAT = 5'b10000
  } pcc_ss_t;

  // ----------------------------------------------------------------
  // pin synchronisers and line events
  // ----------------------------------------------------------------
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_q, sda_q;
  always_ff @(posedge core_clk) begin
    scl_s_q <= {scl_s_q[0], scl_i};
    sda_s_q <= {sda_s_q[0], sda_i};
    scl_q   <= scl_s_q[1];
    sda_q   <= sda_s_q[1];
  end
  wire scl_rise = scl_s_q[1] & ~scl_q;
  wire scl_fall = ~scl_s_q[1] & scl_q;
  wire start_ev = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
  wire stop_ev  = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  pcc_ss_t    st_q;
  logic [3:0] bitn_q;
  logic [7:0] sh_q, ptr_q;
  logic       ack_q, rw_q, nack_q, skip_q;
  wire        last_bit = (bitn_q == 4'h7);
  wire        dev_hit  = (sh_q[7:1] == DEV_ADDR);

  assign rd_addr = ptr_q;
  assign sda_o   = 1'b0;  // open drain: only ever pulls low
  assign sda_oe  = ack_q | ((st_q == SS_RDAT) & ~bitn_q[3] & ~sh_q[7]);

  always_ff @(posedge core_clk) begin
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    if (!rst_b) begin
      st_q   <= SS_IDLE;
      bitn_q <= 4'h0;
      sh_q   <= 8'h00;
      ptr_q  <= 8'h00;
      ack_q  <= 1'b0;
      rw_q   <= 1'b0;
      nack_q <= 1'b0;
      skip_q <= 1'b0;
      req    <= '0;
    end else if (start_ev) begin
      // the scl fall that closes a start is not a data bit
      skip_q <= 1'b1;
      st_q   <= SS_DEV;
      bitn_q <= 4'h0;
      ack_q  <= 1'b0;
    end else if (stop_ev) begin
      st_q  <= SS_IDLE;
      ack_q <= 1'b0;
    end else if (scl_rise && st_q != SS_IDLE) begin
      skip_q <= 1'b0;
      if (bitn_q[3])
        nack_q <= sda_q;
      else if (st_q != SS_RDAT)
        sh_q <= {sh_q[6:0], sda_q};
    end else if (scl_fall && st_q != SS_IDLE && !skip_q) begin
      if (last_bit) begin
        bitn_q <= 4'h8;
        unique case (st_q)
          SS_DEV: begin
            if (dev_hit) begin
              ack_q <= 1'b1;
              rw_q  <= sh_q[0];
            end else begin
              st_q <= SS_IDLE;
            end
          end
          SS_REG: begin
            ptr_q <= sh_q;
            ack_q <= 1'b1;
          end
          SS_WDAT: begin
            req   <= '{wr: 1'b1, rd: 1'b0, addr: ptr_q, wdata: sh_q};
            ptr_q <= ptr_q + 8'h01;
            ack_q <= 1'b1;
          end
          SS_RDAT: ;
          default: st_q <= SS_IDLE;
        endcase
      end else if (bitn_q[3]) begin
        ack_q  <= 1'b0;
        bitn_q <= 4'h0;
        if ((st_q == SS_DEV && rw_q) || (st_q == SS_RDAT && !nack_q)) begin
          st_q  <= SS_RDAT;
          sh_q  <= rd_data;
          req   <= '{wr: 1'b0, rd: 1'b1, addr: ptr_q, wdata: 8'h00};
          ptr_q <= ptr_q + 8'h01;
        end else if (st_q == SS_DEV) begin
          st_q <= SS_REG;
        end else if (st_q == SS_RDAT) begin
          st_q <= SS_IDLE;
        end else begin
          st_q <= SS_WDAT;
        end
      end else begin
        bitn_q <= bitn_q + 4'h1;
        if (st_q == SS_RDAT)
          sh_q <= {sh_q[6:0], 1'b0};
      end
    end
  end
endmodule

// ===== logic/pcc_cal_bank.sv
// synth2 calibration wait bank with saturating program-cycle counter
`timescale 1ns/1ps

// Behaviour
// - closed-loop code resets 0; codes give 30us, 300us, 30ms, 300ms
// - oscillator wait code resets 1; codes give 20us, 400us, 8ms, 200ms
// - bandwidth-mode bit resets 0; set selects 200 Hz jitter cleaner loop
// - read-only 8-bit count rises by one after each erase/program cycle
// - count stops at 255 and never wraps
// - hardware writes the count into nonvolatile storage, no software needed
// - count reloads after reset, commit and program; reads zero before
// - program starts only right after correct unlock write; bit self-clears
module pcc_cal_bank
  import pcc_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR     = 7'h50,  // arbitrary value
  parameter logic [19:0] CL_WAIT2_US  = 20'(PCC_CL_WAIT2_MS * 1000),
  parameter logic [19:0] CL_WAIT3_US  = 20'(PCC_CL_WAIT3_MS * 1000),
  parameter logic [19:0] OSC_WAIT2_US = 20'(PCC_OSC_WAIT2_MS * 1000),
  parameter logic [19:0] OSC_WAIT3_US = 20'(PCC_OSC_WAIT3_MS * 1000),
  parameter logic [19:0] PROG_US      = 20'(PCC_PROG_MS * 1000),
  parameter logic [5:0]  US_DIV       = 6'(PCC_US_DIV)
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output      logic       sda_o,
  output      logic       sda_oe,
  input  wire logic       cal_start,
  output      logic       cal_busy,
  output      logic       cal_done,
  output      logic       synth2_bandwidth_mode,
  input  wire logic [7:0] nv_count_in,
  output      logic       nv_count_wr,
  output      logic [7:0] nv_count_wdata
);
  typedef enum logic [2:0] {
    CS_IDLE = 3'b001,
    CS_OSC  = 3'b010,
    CS_CLSD = 3'b100
  } pcc_cal_st_t;

  function automatic logic [19:0] wait_us(input logic       closed,
                                          input logic [1:0] code);
    logic [19:0] t;
    t = 20'h0_0000;
    unique case ({closed, code})
      3'b000:  t = 20'(PCC_OSC_WAIT0_US);
      3'b001:  t = 20'(PCC_OSC_WAIT1_US);
      3'b010:  t = OSC_WAIT2_US;
      3'b011:  t = OSC_WAIT3_US;
      3'b100:  t = 20'(PCC_CL_WAIT0_US);
      3'b101:  t = 20'(PCC_CL_WAIT1_US);
      3'b110:  t = CL_WAIT2_US;
      3'b111:  t = CL_WAIT3_US;
    endcase
    return t;
  endfunction

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  pcc_req_t   req;
  logic [7:0] rd_addr, rd_data;

  pcc_serial_slave #(.DEV_ADDR(DEV_ADDR)) u_port (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data),
    .req      (req)
  );

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic [1:0] cl_wait_q, osc_wait_q;
  logic       bw_mode_q, armed_q, busy_q, reload_q, nv_wr_q;
  logic [7:0] count_q, nv_wdata_q;

  wire wr_cal   = req.wr && req.addr == PCC_SYNTH2_CAL_WAIT_REG;
  wire wr_bw    = req.wr && req.addr == PCC_SYNTH2_BANDWIDTH_REG;
  wire wr_ctrl  = req.wr && req.addr == PCC_PROGRAM_CTRL_REG;
  wire wr_unlk  = req.wr && req.addr == PCC_PROGRAM_UNLOCK_REG;
  wire prog_go  = wr_ctrl && req.wdata[PCC_PROG_START_BIT] && armed_q
                  && !busy_q;
  wire commit   = wr_ctrl && req.wdata[PCC_COMMIT_BIT];
  wire [7:0] count_inc = (count_q == PCC_COUNT_MAX) ? PCC_COUNT_MAX
                         : count_q + 8'h01;

  // start and commit bits are never stored, so they read back as zero
  assign rd_data =
    (rd_addr == PCC_SYNTH2_CAL_WAIT_REG)  ? {4'h0, cl_wait_q, osc_wait_q} :
    (rd_addr == PCC_SYNTH2_BANDWIDTH_REG) ? {7'h00, bw_mode_q} :
    (rd_addr == PCC_PROGRAM_CYCLE_COUNT)  ? count_q :
    (rd_addr == PCC_PROGRAM_CTRL_REG)     ? {5'h00, busy_q, 2'h0} :
    8'h00;

  assign synth2_bandwidth_mode = bw_mode_q;
  assign nv_count_wr           = nv_wr_q;
  assign nv_count_wdata        = nv_wdata_q;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cl_wait_q  <= PCC_CL_WAIT_RST;
      osc_wait_q <= PCC_OSC_WAIT_RST;
      bw_mode_q  <= PCC_BW_MODE_RST;
    end else begin
      if (wr_cal) begin
        cl_wait_q  <= req.wdata[PCC_CL_WAIT_LSB +: 2];
        osc_wait_q <= req.wdata[PCC_OSC_WAIT_LSB +: 2];
      end
      if (wr_bw)
        bw_mode_q <= req.wdata[PCC_BW_MODE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // microsecond tick, shared by both timers
  // ----------------------------------------------------------------
  logic [5:0] div_q;
  wire        us_tick = (div_q == US_DIV - 6'h01);
  always_ff @(posedge core_clk) begin
    if (!rst_b || us_tick)
      div_q <= 6'h00;
    else
      div_q <= div_q + 6'h01;
  end

  // ----------------------------------------------------------------
  // program cycle and counter
  // ----------------------------------------------------------------
  logic [19:0] prog_cnt_q;
  always_ff @(posedge core_clk) begin
    nv_wr_q <= 1'b0;
    if (!rst_b) begin
      armed_q    <= 1'b0;
      busy_q     <= 1'b0;
      prog_cnt_q <= 20'h0_0000;
      count_q    <= PCC_COUNT_RST;
      reload_q   <= 1'b1;
      nv_wdata_q <= PCC_COUNT_RST;
    end else begin
      // any access other than a matching unlock write disarms
      if (req.wr || req.rd)
        armed_q <= wr_unlk && req.wdata == PCC_UNLOCK_CODE;
      reload_q <= commit || nv_wr_q;
      if (reload_q)
        count_q <= nv_count_in;
      if (prog_go) begin
        busy_q     <= 1'b1;
        prog_cnt_q <= PROG_US;
      end else if (busy_q && us_tick) begin
        if (prog_cnt_q <= 20'h0_0001) begin
          busy_q     <= 1'b0;
          nv_wr_q    <= 1'b1;
          nv_wdata_q <= count_inc;
        end else begin
          prog_cnt_q <= prog_cnt_q - 20'h0_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration wait sequencer: oscillator wait, then closed loop
  // ----------------------------------------------------------------
  pcc_cal_st_t cst_q;
  logic [19:0] cal_cnt_q;
  logic        done_q;
  wire         cal_zero = (cal_cnt_q <= 20'h0_0001);
  assign cal_busy = (cst_q != CS_IDLE);
  assign cal_done = done_q;

  always_ff @(posedge core_clk) begin
    done_q <= 1'b0;
    if (!rst_b) begin
      cst_q     <= CS_IDLE;
      cal_cnt_q <= 20'h0_0000;
    end else begin
      unique case (cst_q)
        CS_IDLE: if (cal_start) begin
          cst_q     <= CS_OSC;
          cal_cnt_q <= wait_us(1'b0, osc_wait_q);
        end
        CS_OSC: if (us_tick) begin
          if (cal_zero) begin
            cst_q     <= CS_CLSD;
            cal_cnt_q <= wait_us(1'b1, cl_wait_q);
          end else begin
            cal_cnt_q <= cal_cnt_q - 20'h0_0001;
          end
        end
        CS_CLSD: if (us_tick) begin
          if (cal_zero) begin
            cst_q  <= CS_IDLE;
            done_q <= 1'b1;
          end else begin
            cal_cnt_q <= cal_cnt_q - 20'h0_0001;
          end
        end
        default: cst_q <= CS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rst_vals_a: assert property (@(posedge core_clk)
    rst_b && !$past(rst_b) |-> cl_wait_q == 2'h0 && osc_wait_q == 2'h1
      && bw_mode_q == 1'b0 && count_q == 8'h00)
    else $error("reset values wrong");
  osc_load_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    cst_q == CS_IDLE && cal_start |=> cst_q == CS_OSC
      && cal_cnt_q == wait_us(1'b0, osc_wait_q))
    else $error("oscillator wait not loaded");
  clsd_load_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    cst_q == CS_OSC && us_tick && cal_zero |=> cst_q == CS_CLSD
      && cal_cnt_q == wait_us(1'b1, cl_wait_q))
    else $error("closed loop wait not loaded");
  bw_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_bw |=> synth2_bandwidth_mode == $past(req.wdata[0]))
    else $error("bandwidth mode not written");
  count_inc_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(busy_q) && count_q != 8'hff |-> nv_count_wdata == count_q + 8'h01)
    else $error("count not incremented");
  count_sat_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(busy_q) && count_q == 8'hff |-> nv_count_wdata == 8'hff)
    else $error("count wrapped");
  nv_store_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(busy_q) |-> nv_count_wr ##1 !nv_count_wr)
    else $error("count not stored");
  count_reload_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    nv_count_wr |=> reload_q ##1 count_q == $past(nv_count_in))
    else $error("count not reloaded");
  unlock_gate_a: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    wr_ctrl && !armed_q && !busy_q |=> !busy_q)
    else $error("program started without unlock");
endmodule

// ===== test/tb.sv
// self-checking bench for the synth2 calibration and program counter bank
`timescale 1ns/1ps
module tb;
  import pcc_pkg::*;
  localparam int         DIV = 4;
  localparam logic [6:0] DEV = 7'h50;  // arbitrary value

  typedef struct {
    logic [1:0] osc;
    logic [1:0] cl;
    int         us;
  } pcc_row_t;

  logic       core_clk;
  logic       rst_b;
  logic       scl_i;
  logic       sda_drv;
  logic       cal_start;
  logic       sda_o;
  logic       sda_oe;
  logic       cal_busy;
  logic       cal_done;
  logic       bw_mode;
  logic       nv_count_wr;
  logic [7:0] nv_q;
  logic [7:0] nv_count_wdata;
  int         n_mismatch;
  int         n_compared;
  int         n_wr = 0;
  logic       seed_en;
  logic [7:0] seed_val;
  logic [7:0] cal_v;
  // open-drain data line with pull-up: either party can pull it low
  wire        sda_i = sda_oe ? (sda_drv & sda_o) : sda_drv;

  // shortened long waits: code 2/3 become tens of microseconds
  pcc_row_t rows [6] = '{'{2'h0, 2'h0, 50}, '{2'h1, 2'h1, 700},
                         '{2'h2, 2'h2, 30}, '{2'h3, 2'h3, 70},
                         '{2'h2, 2'h1, 310}, '{2'h1, 2'h0, 430}};

  pcc_cal_bank #(
    .DEV_ADDR(DEV), .CL_WAIT2_US(20'd20), .CL_WAIT3_US(20'd30),
    .OSC_WAIT2_US(20'd10), .OSC_WAIT3_US(20'd40), .PROG_US(20'd20),
    .US_DIV(6'(DIV))
  ) pcc_cal_bank_inst (
    .core_clk(core_clk), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .cal_start(cal_start),
    .cal_busy(cal_busy), .cal_done(cal_done),
    .synth2_bandwidth_mode(bw_mode), .nv_count_in(nv_q),
    .nv_count_wr(nv_count_wr), .nv_count_wdata(nv_count_wdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // nonvolatile array model: keeps its value across rst_b
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (nv_count_wr === 1'b1) begin
      nv_q <= nv_count_wdata;
      n_wr <= n_wr + 1;
    end else if (seed_en) begin
      nv_q <= seed_val;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic half();
    repeat (6) @(negedge core_clk);
  endtask

  // data only moves while the serial clock is low
  task automatic bit_x(input logic b, output logic r);
    sda_drv = b;
    half();
    scl_i = 1'b1;
    half();
    r = sda_i;
    scl_i = 1'b0;
    half();
  endtask

  task automatic byte_x(input logic [7:0] d, output logic [7:0] q,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  task automatic start_c();
    sda_drv = 1'b1;
    half();
    scl_i = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl_i = 1'b0;
    half();
  endtask

  task automatic stop_c();
    sda_drv = 1'b0;
    half();
    scl_i = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start_c();
    byte_x({DEV, 1'b0}, q, k);
    chk({7'h0, k}, 8'h01);
    byte_x(a, q, k);
    chk({7'h0, k}, 8'h01);
    byte_x(d, q, k);
    stop_c();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic [7:0] d;
    logic       k;
    start_c();
    byte_x({DEV, 1'b0}, q, k);
    byte_x(a, q, k);
    start_c();
    byte_x({DEV, 1'b1}, q, k);
    byte_x(8'hff, d, k);
    stop_c();
    chk(d, exp);
  endtask

  task automatic run_cal(input int us);
    int n;
    n = 0;
    cal_start = 1'b1;
    @(negedge core_clk);
    cal_start = 1'b0;
    chk({7'h0, cal_busy}, 8'h01);
    while (cal_done !== 1'b1 && n < 8000) begin
      @(negedge core_clk);
      n++;
    end
    // one tick of slack on each of the two waits
    chk(8'(n >= (us - 2) * DIV && n <= (us + 2) * DIV + 2), 8'h01);
  endtask

  task automatic prog(input logic armed, input logic [7:0] exp_nv);
    int n;
    int w0;
    n = 0;
    reg_wr(PCC_PROGRAM_UNLOCK_REG, PCC_UNLOCK_CODE);
    if (!armed) begin
      reg_wr(PCC_SYNTH2_BANDWIDTH_REG, 8'h00);
    end
    w0 = n_wr;
    reg_wr(PCC_PROGRAM_CTRL_REG, 8'h01);
    while (n_wr == w0 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk(8'(n_wr - w0), {7'h0, armed});
    chk(nv_q, exp_nv);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    scl_i = 1'b1;
    sda_drv = 1'b1;
    cal_start = 1'b0;
    seed_val = 8'h07;
    seed_en = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    repeat (16) @(negedge core_clk);
    seed_en = 1'b0;
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    rd_chk(PCC_SYNTH2_CAL_WAIT_REG, 8'h01);
    rd_chk(PCC_SYNTH2_BANDWIDTH_REG, 8'h00);
    chk({7'h0, bw_mode}, 8'h00);
    rd_chk(PCC_PROGRAM_CYCLE_COUNT, 8'h07);
    $display("test reset_values done");
    foreach (rows[i]) begin
      cal_v = {4'h0, rows[i].cl, rows[i].osc};
      reg_wr(PCC_SYNTH2_CAL_WAIT_REG, cal_v);
      rd_chk(PCC_SYNTH2_CAL_WAIT_REG, cal_v);
      run_cal(rows[i].us);
    end
    $display("test wait_codes done");
    reg_wr(PCC_SYNTH2_BANDWIDTH_REG, 8'h01);
    chk({7'h0, bw_mode}, 8'h01);
    rd_chk(PCC_SYNTH2_BANDWIDTH_REG, 8'h01);
    reg_wr(PCC_SYNTH2_CAL_WAIT_REG, 8'h0d);
    rd_chk(PCC_SYNTH2_CAL_WAIT_REG, 8'h0d);
    reg_wr(PCC_SYNTH2_BANDWIDTH_REG, 8'h00);
    chk({7'h0, bw_mode}, 8'h00);
    $display("test bandwidth done");
    reg_wr(PCC_PROGRAM_CYCLE_COUNT, 8'h55);
    rd_chk(PCC_PROGRAM_CYCLE_COUNT, 8'h07);
    rd_chk(8'h80, 8'h00);
    prog(1'b1, 8'h08);
    rd_chk(PCC_PROGRAM_CYCLE_COUNT, 8'h08);
    prog(1'b0, 8'h08);
    $display("test program done");
    seed_val = 8'hfe;
    seed_en = 1'b1;
    @(negedge core_clk);
    seed_en = 1'b0;
    reg_wr(PCC_PROGRAM_CTRL_REG, 8'h08);
    rd_chk(PCC_PROGRAM_CYCLE_COUNT, 8'hfe);
    prog(1'b1, 8'hff);
    prog(1'b1, 8'hff);
    rd_chk(PCC_PROGRAM_CYCLE_COUNT, 8'hff);
    $display("test saturation done");
    reg_wr(PCC_SYNTH2_BANDWIDTH_REG, 8'h01);
    chk({7'h0, bw_mode}, 8'h01);
    rst_b = 1'b0;
    repeat (4) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    rd_chk(PCC_PROGRAM_CYCLE_COUNT, 8'hff);
    rd_chk(PCC_SYNTH2_CAL_WAIT_REG, 8'h01);
    rd_chk(PCC_SYNTH2_BANDWIDTH_REG, 8'h00);
    chk({7'h0, bw_mode}, 8'h00);
    $display("test second_reset done");
    give_verdict();
  end

  // watchdog: expected run is about 30k cycles
  initial begin
    #2_000_000;
    n_mismatch++;
    give_verdict();
  end
endmodule
